// [src/emct_timer.v]
// Purpose: 16-bit eight-mode capture/compare timer with AXI4-Lite registers.
// Assumes: Inputs synchronous to aclk; reset synchronous, active low.
// Notes:   Event edges act on aclk; counting acts on the selected tick.
// Operation
// - Periodic mode counts to compare, flags, restarts.
// - Top below count: run to all-ones, wrap.
// - Timeout: start edge starts, other edge stops.
// - Timeout reaching top sets flag, emits event.
// - Frozen timeout counter restarts on start edge.
// - Frozen reads and run writes change nothing.
// - Capture mode: edge copies count, flags, events.
// - Capture modes: compare low read clears flag.
// - Frequency mode: edge captures then restarts counter.
// - Pulse width: rise restarts, fall captures, alternates.
// - Freq+width: rise start, fall capture, rise stops.
// - Single-shot: low when stopped, edge starts pulse.
// - Single-shot stops at compare, ignores events briefly.
// - Synchronous single-shot output rises two cycles later.
// - Single-shot runs on enable unless count equals top.
// - Immediate option sets output at the edge.
// - Immediate option: counter starts two-three ticks later.
// - PWM8: period low byte plus one, duty high.
// - Mode field codes 0 to 7 in order.
// - Initial level only matters outside PWM, single-shot.
// - Override puts waveform onto the port pin.
`include "emct_defines.vh"

module emct_timer #(
	parameter AW = 6                        // AXI address width
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [AW-1:0] s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire          event_in,
	input  wire          tca_tick_in,
	input  wire          port_out_value,
	output reg           waveform_pin_q,
	output reg           event_out_q,
	output reg           irq_q
);

	// Register index from a byte address
	function [3:0] fn_idx;
		input [AW-1:0] a;
		begin
			fn_idx = a[5:2];
		end
	endfunction

	// Byte-lane merge into a 16-bit register
	function [15:0] fn_merge;
		input [15:0] old;
		input [31:0] d;
		input [3:0]  s;
		begin
			fn_merge[7:0]  = s[0] ? d[7:0] : old[7:0];
			fn_merge[15:8] = s[1] ? d[15:8] : old[15:8];
		end
	endfunction

	// Software registers
	reg  [7:0]    ctrl_a_q;                 // Enable, tick select
	reg  [7:0]    ctrl_b_q;                 // Mode, override, init, async
	reg  [7:0]    ev_ctrl_q;                // Event enable, edge
	reg           int_en_q;                 // Interrupt enable
	reg  [15:0]   count_value_q;            // Counter
	reg  [15:0]   compare_value_reg_q;      // Compare / capture

	// Timer state
	reg           event_match_flag_q;       // Sticky match flag
	reg           run_q;                    // Counter running
	reg           wave_q;                   // Internal waveform
	reg           ev_prev_q;                // Last event level
	reg           en_prev_q;                // Last enable value
	reg           div2_q;                   // Half-rate toggle
	reg           hold_q;                   // Single-shot lockout
	reg           pend_q;                   // Single-shot start pending
	reg  [1:0]    fpw_q;                    // Freq+width phase

	// Write channel holding
	reg           aw_have_q;
	reg           w_have_q;
	reg  [AW-1:0] awaddr_q;
	reg  [31:0]   wdata_q;
	reg  [3:0]    wstrb_q;

	// Field views
	wire          enable    = ctrl_a_q[`EMCT_A_ENABLE];
	wire [1:0]    clksel    = ctrl_a_q[`EMCT_A_CLKSEL_HI:`EMCT_A_CLKSEL_LO];
	wire [2:0]    timer_mode_select = ctrl_b_q[`EMCT_B_MODE_HI:`EMCT_B_MODE_LO];
	wire          waveform_pin_override = ctrl_b_q[`EMCT_B_OVERRIDE];
	wire          pin_initial_level = ctrl_b_q[`EMCT_B_INIT];
	wire          async_out = ctrl_b_q[`EMCT_B_ASYNC];
	wire          captei    = ev_ctrl_q[`EMCT_E_CAPTEI];
	wire          edge_sel  = ev_ctrl_q[`EMCT_E_EDGE];
	wire [7:0]    pwm_period_byte = compare_value_reg_q[7:0];
	wire [7:0]    pwm_duty_byte   = compare_value_reg_q[15:8];

	// Tick: one timer clock step, gated by enable
	wire          timer_tick_clock = enable & ((clksel == `EMCT_CK_DIV1) ? 1'b1 :
	                                (clksel == `EMCT_CK_DIV2) ? div2_q : tca_tick_in);

	// Edge detection; source keeps pulses wide enough to be seen
	wire          pos_e  = enable & captei & event_in & ~ev_prev_q;
	wire          neg_e  = enable & captei & ~event_in & ev_prev_q;
	wire          sel_e  = edge_sel ? neg_e : pos_e;                  // Selected polarity
	wire          oth_e  = edge_sel ? pos_e : neg_e;                  // Opposite polarity
	wire          at_top = (count_value_q == compare_value_reg_q);
	wire [15:0]   cnt_inc = count_value_q + 16'h0001;
	wire [7:0]    pwm_nxt = (count_value_q[7:0] == pwm_period_byte) ? 8'h00 :
	                        count_value_q[7:0] + 8'h01;

	// Capture modes share flag auto-clear
	wire          cap_mode = (timer_mode_select >= `EMCT_M_CAPTURE) &&
	                         (timer_mode_select <= `EMCT_M_FREQ_PW);

	// Single-shot accepted start edge
	wire          ss_go  = (timer_mode_select == `EMCT_M_SINGLE) & sel_e &
	                       ~run_q & ~hold_q & ~pend_q;

	// Bus fires
	wire          wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire [3:0]    wr_idx  = fn_idx(awaddr_q);
	wire          rd_fire = s_axi_arvalid & s_axi_arready;
	wire [3:0]    rd_idx  = fn_idx(s_axi_araddr);
	wire          cnt_wr  = wr_fire & (wr_idx == `EMCT_IDX_COUNT);
	wire          cmp_wr  = wr_fire & (wr_idx == `EMCT_IDX_COMPARE);
	// Reading the compare low byte only clears in capture modes, so a read
	// in frozen timeout mode leaves all state alone
	wire          cmp_rd  = rd_fire & (rd_idx == `EMCT_IDX_COMPARE) & cap_mode;

	// Flag set sources from timer logic
	reg           set_flag;

	// Write address and data are held until both are present
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= {AW{1'b0}};
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EMCT_RESP_OKAY;
		end else begin
			// Ready only while the holding slot is empty
			s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			// Response follows the register update
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (wr_idx)
					`EMCT_IDX_CTRL_A, `EMCT_IDX_CTRL_B, `EMCT_IDX_EV_CTRL,
					`EMCT_IDX_INT_CTRL, `EMCT_IDX_INT_FLAG, `EMCT_IDX_STATUS,
					`EMCT_IDX_COUNT, `EMCT_IDX_COMPARE: begin
						s_axi_bresp <= `EMCT_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `EMCT_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read in flight, data one cycle after address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `EMCT_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `EMCT_RESP_OKAY;
				case (rd_idx)
					`EMCT_IDX_CTRL_A:   s_axi_rdata <= {24'h000000, ctrl_a_q};
					`EMCT_IDX_CTRL_B:   s_axi_rdata <= {24'h000000, ctrl_b_q};
					`EMCT_IDX_EV_CTRL:  s_axi_rdata <= {24'h000000, ev_ctrl_q};
					`EMCT_IDX_INT_CTRL: s_axi_rdata <= {31'h00000000, int_en_q};
					`EMCT_IDX_INT_FLAG: s_axi_rdata <= {31'h00000000, event_match_flag_q};
					`EMCT_IDX_STATUS:   s_axi_rdata <= {31'h00000000, run_q};
					`EMCT_IDX_COUNT:    s_axi_rdata <= {16'h0000, count_value_q};
					`EMCT_IDX_COMPARE:  s_axi_rdata <= {16'h0000, compare_value_reg_q};
					default: begin
						// Unmapped: zero data, slave error
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `EMCT_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control registers; status is read-only so run writes are ignored
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a_q  <= `EMCT_RST_BYTE;
			ctrl_b_q  <= `EMCT_RST_BYTE;
			ev_ctrl_q <= `EMCT_RST_BYTE;
			int_en_q  <= 1'b0;
		end else if (wr_fire && wstrb_q[0]) begin
			case (wr_idx)
				`EMCT_IDX_CTRL_A:   ctrl_a_q  <= wdata_q[7:0];
				`EMCT_IDX_CTRL_B:   ctrl_b_q  <= wdata_q[7:0];
				`EMCT_IDX_EV_CTRL:  ev_ctrl_q <= wdata_q[7:0];
				`EMCT_IDX_INT_CTRL: int_en_q  <= wdata_q[0];
				default: begin
					// Other indices handled elsewhere or ignored
				end
			endcase
		end
	end

	// Tick generator and edge history
	always @(posedge aclk) begin
		if (!aresetn) begin
			div2_q    <= 1'b0;
			ev_prev_q <= 1'b0;
			en_prev_q <= 1'b0;
		end else begin
			div2_q    <= enable ? ~div2_q : 1'b0;
			ev_prev_q <= event_in;
			en_prev_q <= enable;
		end
	end

	// Main counter, compare, waveform and mode sequencing
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_value_q       <= `EMCT_RST_WORD;
			compare_value_reg_q <= `EMCT_RST_WORD;
			run_q               <= 1'b0;
			wave_q              <= 1'b0;
			hold_q              <= 1'b0;
			pend_q              <= 1'b0;
			fpw_q               <= 2'h0;
			set_flag            <= 1'b0;
		end else begin
			set_flag <= 1'b0;
			pend_q   <= 1'b0;
			case (timer_mode_select)
				`EMCT_M_PERIODIC: begin
					run_q  <= enable;
					wave_q <= pin_initial_level;
					if (timer_tick_clock) begin
						// Equal top restarts; a top below count wraps at all-ones
						count_value_q <= at_top ? 16'h0000 : cnt_inc;
						if (at_top)
							set_flag <= 1'b1;
					end
				end
				`EMCT_M_TIMEOUT: begin
					wave_q <= pin_initial_level;
					if (sel_e) begin
						// Start, also out of the frozen state
						run_q         <= 1'b1;
						count_value_q <= 16'h0000;
					end else if (oth_e) begin
						run_q <= 1'b0;
					end else if (run_q && timer_tick_clock) begin
						count_value_q <= cnt_inc;
						if (at_top)
							set_flag <= 1'b1;
					end
				end
				`EMCT_M_CAPTURE: begin
					run_q  <= enable;
					wave_q <= pin_initial_level;
					if (timer_tick_clock)
						count_value_q <= cnt_inc;
					if (sel_e) begin
						compare_value_reg_q <= count_value_q;
						set_flag            <= 1'b1;
					end
				end
				`EMCT_M_FREQ: begin
					run_q  <= enable;
					wave_q <= pin_initial_level;
					if (sel_e) begin
						compare_value_reg_q <= count_value_q;
						count_value_q       <= 16'h0000;
						set_flag            <= 1'b1;
					end else if (timer_tick_clock) begin
						count_value_q <= cnt_inc;
					end
				end
				`EMCT_M_PWIDTH: begin
					run_q  <= enable;
					wave_q <= pin_initial_level;
					// Both polarities watched; rise restarts, fall captures
					if (pos_e) begin
						count_value_q <= 16'h0000;
					end else if (neg_e) begin
						compare_value_reg_q <= count_value_q;
						set_flag            <= 1'b1;
					end else if (timer_tick_clock) begin
						count_value_q <= cnt_inc;
					end
				end
				`EMCT_M_FREQ_PW: begin
					wave_q <= pin_initial_level;
					case (fpw_q)
						2'h0: begin
							// Idle until a rise
							if (pos_e) begin
								count_value_q <= 16'h0000;
								run_q         <= 1'b1;
								fpw_q         <= 2'h1;
							end
						end
						2'h1: begin
							if (neg_e) begin
								compare_value_reg_q <= count_value_q;
								fpw_q               <= 2'h2;
							end
						end
						2'h2: begin
							if (pos_e) begin
								run_q    <= 1'b0;
								set_flag <= 1'b1;
								fpw_q    <= 2'h3;
							end
						end
						default: begin
							// Stopped until compare read rearms
							if (cmp_rd)
								fpw_q <= 2'h0;
						end
					endcase
					if (run_q && timer_tick_clock && !pos_e && fpw_q != 2'h0)
						count_value_q <= cnt_inc;
				end
				`EMCT_M_SINGLE: begin
					if (ss_go) begin
						pend_q <= 1'b1;
						wave_q <= 1'b1;
					end
					if (pend_q) begin
						// Counter restarts one cycle after the accepted edge
						count_value_q <= 16'h0000;
						run_q         <= 1'b1;
					end else if (enable && !en_prev_q && !at_top) begin
						run_q  <= 1'b1;
						wave_q <= 1'b1;
					end else if (run_q && timer_tick_clock) begin
						if (at_top) begin
							run_q    <= 1'b0;
							wave_q   <= 1'b0;
							hold_q   <= 1'b1;
							set_flag <= 1'b1;
						end else begin
							count_value_q <= cnt_inc;
						end
					end else if (timer_tick_clock) begin
						hold_q <= 1'b0;
					end
					if (!run_q && !pend_q && !ss_go && !hold_q)
						wave_q <= 1'b0;
				end
				default: begin
					// PWM8: low byte period, high byte duty
					run_q <= enable;
					if (timer_tick_clock) begin
						count_value_q <= {8'h00, pwm_nxt};
						if (pwm_nxt == 8'h00) begin
							wave_q   <= 1'b1;
							set_flag <= 1'b1;
						end else if (pwm_nxt == pwm_duty_byte) begin
							wave_q <= 1'b0;
						end
					end
				end
			endcase
			if (!enable && timer_mode_select != `EMCT_M_SINGLE)
				run_q <= 1'b0;
			// Software writes win over counting
			if (cnt_wr)
				count_value_q <= fn_merge(count_value_q, wdata_q, wstrb_q);
			if (cmp_wr)
				compare_value_reg_q <= fn_merge(compare_value_reg_q, wdata_q, wstrb_q);
		end
	end

	// Flag: write-one clear or compare read clear; a set in the same cycle wins
	always @(posedge aclk) begin
		if (!aresetn) begin
			event_match_flag_q <= 1'b0;
			event_out_q        <= 1'b0;
			irq_q              <= 1'b0;
		end else begin
			if (cmp_rd)
				event_match_flag_q <= 1'b0;
			if (wr_fire && wr_idx == `EMCT_IDX_INT_FLAG && wstrb_q[0] && wdata_q[0])
				event_match_flag_q <= 1'b0;
			if (set_flag)
				event_match_flag_q <= 1'b1;
			event_out_q <= set_flag;
			irq_q       <= int_en_q & (event_match_flag_q | set_flag);
		end
	end

	// Pin mux; immediate option lifts the pin in the edge's own cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			waveform_pin_q <= 1'b0;
		end else if (!waveform_pin_override) begin
			waveform_pin_q <= port_out_value;
		end else if (ss_go && async_out) begin
			waveform_pin_q <= 1'b1;
		end else begin
			waveform_pin_q <= wave_q;
		end
	end

endmodule // emct_timer

// [src/emct_defines.vh]
// Purpose: Shared constants for the eight-mode capture timer.
// Assumes: Register index times four gives the AXI byte address.
// Notes:   Definitions only.
`ifndef EMCT_DEFINES_VH
`define EMCT_DEFINES_VH

// Register indices
`define EMCT_IDX_CTRL_A   4'h0
`define EMCT_IDX_CTRL_B   4'h1
`define EMCT_IDX_EV_CTRL  4'h4
`define EMCT_IDX_INT_CTRL 4'h5
`define EMCT_IDX_INT_FLAG 4'h6
`define EMCT_IDX_STATUS   4'h7
`define EMCT_IDX_COUNT    4'hA
`define EMCT_IDX_COMPARE  4'hC

// Field positions
`define EMCT_A_ENABLE     0
`define EMCT_A_CLKSEL_LO  1
`define EMCT_A_CLKSEL_HI  2
`define EMCT_B_MODE_LO    0
`define EMCT_B_MODE_HI    2
`define EMCT_B_OVERRIDE   4
`define EMCT_B_INIT       5
`define EMCT_B_ASYNC      6
`define EMCT_E_CAPTEI     0
`define EMCT_E_EDGE       4

// Reset values
`define EMCT_RST_BYTE     8'h00
`define EMCT_RST_WORD     16'h0000

// Timer modes
`define EMCT_M_PERIODIC   3'h0
`define EMCT_M_TIMEOUT    3'h1
`define EMCT_M_CAPTURE    3'h2
`define EMCT_M_FREQ       3'h3
`define EMCT_M_PWIDTH     3'h4
`define EMCT_M_FREQ_PW    3'h5
`define EMCT_M_SINGLE     3'h6
`define EMCT_M_PWM8       3'h7

// Tick sources
`define EMCT_CK_DIV1      2'h0
`define EMCT_CK_DIV2      2'h1

// Bus responses
`define EMCT_RESP_OKAY    2'h0
`define EMCT_RESP_SLVERR  2'h2

`endif

// [verification/emct_event_src.sv]
// Purpose: Event channel model driving the timer's event input.
// Assumes: A level changes only on request, just after a clock edge.
// Notes:   Each level is held at least HOLD plus one cycles, so no pulse is ever too short.
module emct_event_src #(
	parameter int HOLD = 3             // Minimum cycles a level stands, less one
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic go,
	input  wire logic level,
	output logic      ev_q,
	output logic      busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_q;                // Cycles left before a new level
	assign busy = (hold_q != 4'h0);
	// Level latch with hold counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			ev_q <= 1'b0;
			hold_q <= 4'h0;
		end else if (go && !busy) begin
			ev_q <= level;
			hold_q <= HOLD[3:0];
		end else if (busy) begin
			hold_q <= hold_q - 4'h1;
		end
	end
endmodule // emct_event_src

// [verification/emct_timer_sva.sv]
// Purpose: Port-level checks for the capture timer.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into every timer instance.
module emct_timer_sva (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        event_out_q,
	input wire        irq_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] idle_q;                // Cycles since a bus request was taken
	// Idle counter; an interrupt may only drop shortly after bus traffic
	always @(posedge aclk) begin
		if (!aresetn || (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)
			|| (s_axi_arvalid && s_axi_arready))
			idle_q <= 4'h0;
		else if (idle_q != 4'hF)
			idle_q <= idle_q + 4'h1;
	end
	a_aw_taken_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high while an address is held");
	a_w_taken_block: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready high while data is held");
	a_ar_rvalid_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready high while rvalid stands");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	a_write_answer_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after request");
	a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after request");
	a_event_one_cycle: assert property (event_out_q |=> !event_out_q)
		else $error("event pulse longer than one cycle");
	a_irq_clear_cause: assert property ($fell(irq_q) |-> idle_q <= 4'h4)
		else $error("interrupt dropped without a register access");
	c_event: cover property (event_out_q);
	c_irq_clear: cover property ($fell(irq_q));
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // emct_timer_sva

bind emct_timer emct_timer_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.event_out_q(event_out_q), .irq_q(irq_q));

// [verification/test_eight_mode_capture_timer.sv]
// Purpose: Self-checking bench for the eight-mode capture timer.
// Assumes: 25 MHz clock; the event model drives the event input.
// Notes:   Register rows first, then mode scenarios and a second reset.
`include "emct_defines.vh"
module test_eight_mode_capture_timer;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [3:0]  idx;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [1:0]  rs;
	} emct_row_t;
	// Register rows: index, written, read back, read response
	emct_row_t rows [16] = '{'{4'h1, 32'h0, 32'h0, 2'h0}, '{4'h1, 32'h1, 32'h1, 2'h0},
		'{4'h1, 32'h2, 32'h2, 2'h0}, '{4'h1, 32'h3, 32'h3, 2'h0}, '{4'h1, 32'h4, 32'h4, 2'h0},
		'{4'h1, 32'h5, 32'h5, 2'h0}, '{4'h1, 32'h6, 32'h6, 2'h0}, '{4'h1, 32'h7, 32'h7, 2'h0},
		'{4'hC, 32'h1234, 32'h1234, 2'h0}, '{4'hA, 32'hAB, 32'hAB, 2'h0},
		'{4'h4, 32'h11, 32'h11, 2'h0}, '{4'h5, 32'h1, 32'h1, 2'h0},
		'{4'h7, 32'h1, 32'h0, 2'h0}, '{4'h2, 32'h5, 32'h0, 2'h2},
		'{4'h3, 32'h1, 32'h0, 2'h2}, '{4'h1, 32'h70, 32'h70, 2'h0}};
	logic [2:0]  mm [4] = '{3'h2, 3'h3, 3'h4, 3'h5};  // Capture modes
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [5:0]  awaddr = 6'h00;
	logic [5:0]  araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        go = 1'b0, lvl = 1'b0, port = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ev, busy, pin, evo, irq;
	logic        ev_d = 1'b0, pin_d = 1'b0;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          n_fail = 0, checked = 0, cyc = 0, t_r = 0, t_f = 0, t_p = 0;
	emct_timer #(.AW(6)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .event_in(ev), .tca_tick_in(1'b0), .port_out_value(port),
		.waveform_pin_q(pin), .event_out_q(evo), .irq_q(irq));
	emct_event_src #(.HOLD(3)) u_src (.aclk(aclk), .aresetn(aresetn), .go(go), .level(lvl),
		.ev_q(ev), .busy(busy));
	// Clock, 40 ns period
	initial begin
		forever #20 aclk = ~aclk;
	end
	// Edge times, all taken from pre-edge samples so no race
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		ev_d <= ev;
		pin_d <= pin;
		if (ev && !ev_d) t_r <= cyc;
		if (!ev && ev_d) t_f <= cyc;
		if (pin && !pin_d) t_p <= cyc;
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] i, input logic [31:0] d, output logic [1:0] r);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			a = a | awready;
			w = w | wready;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic wq(input logic [3:0] i, input logic [31:0] d);
		logic [1:0] r;
		wr(i, d, r);
	endtask
	task automatic rd(input logic [3:0] i, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Ask the event model for a new level, wait out its hold
	task automatic evt(input logic v);
		@(posedge aclk);
		go <= 1'b1;
		lvl <= v;
		@(posedge aclk);
		go <= 1'b0;
		tick();
		while (busy) tick();
	endtask
	// Cycles the pin stays at one level, bounded
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (pin === v && n < 300) begin
			tick();
			n++;
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge aclk);
		n_fail++;
		summarize();
	end
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n, h, t1, e;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].idx, rows[k].wd, r);
			if (rows[k].rs == 2'h2) chk("bresp", 32'h2, r);
			rd(rows[k].idx, d, r);
			chk("rdata", rows[k].rd, d);
			chk("rresp", rows[k].rs, r);
		end
		$display("test rows done");
		// Periodic: idle level from init bit, then period compare plus one
		wq(4'hC, 32'h5);
		wq(4'hA, 32'h0);
		wq(4'h1, 32'h30);
		tick(2);
		chk("pin_init", 32'h1, pin);
		wq(4'h0, 32'h1);
		n = 0;
		while (evo !== 1'b1 && n < 50) begin
			tick();
			n++;
		end
		n = 0;
		do begin
			tick();
			n++;
		end while (evo !== 1'b1 && n < 50);
		chk("period", 32'd6, n);
		$display("test periodic done");
		// Capture modes: rise, fall, rise; flag raises irq, compare read clears it
		foreach (mm[k]) begin
			wq(4'h0, 32'h0);
			wq(4'h1, {29'h0, mm[k]});
			wq(4'hA, 32'h0);
			wq(4'h4, 32'h1);
			wq(4'h6, 32'h1);
			wq(4'h0, 32'h1);
			evt(1'b1);
			t1 = t_r;
			tick(5);
			evt(1'b0);
			tick(7);
			evt(1'b1);
			tick(3);
			chk("irq_set", 32'h1, irq);
			if (mm[k] == 3'h5) begin
				rd(4'hA, d, r);
				chk("fpw_count", 32'h1, (d + 1 >= t_r - t1) && (d <= t_r - t1));
			end
			rd(4'hC, d, r);
			e = (mm[k] == 3'h3) ? t_r - t1 : t_f - t1;
			if (mm[k] != 3'h2) chk("capture", 32'h1, (d + 1 >= e) && (d <= e + 1));
			tick(3);
			chk("irq_clr", 32'h0, irq);
			evt(1'b0);
		end
		$display("test capture done");
		// PWM8: period low byte plus one, high for duty byte
		wq(4'h0, 32'h0);
		wq(4'hC, 32'h0309);
		wq(4'hA, 32'h0);
		wq(4'h1, 32'h17);
		wq(4'h0, 32'h1);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, h);
		run_len(1'b0, n);
		chk("pwm_high", 32'd3, h);
		chk("pwm_low", 32'd7, n);
		$display("test pwm done");
		// Single-shot: count at top holds it, then sync and immediate starts
		wq(4'h0, 32'h0);
		wq(4'hC, 32'h4);
		wq(4'hA, 32'h4);
		wq(4'h1, 32'h16);
		wq(4'h0, 32'h1);
		tick(8);
		chk("ss_idle", 32'h0, pin);
		for (int a = 0; a < 2; a++) begin
			wq(4'h1, 32'h16 | (a << 6));
			evt(1'b1);
			chk("ss_rise", 2 - a, t_p - t_r);
			tick(12);
			chk("ss_stop", 32'h0, pin);
			evt(1'b0);
		end
		$display("test single done");
		// Timeout: rise starts, fall freezes short of top, new rise runs to top
		wq(4'h0, 32'h0);
		wq(4'h1, 32'h1);
		wq(4'hC, 32'h8);
		wq(4'h6, 32'h1);
		wq(4'h0, 32'h1);
		evt(1'b1);
		evt(1'b0);
		rd(4'hA, d, r);
		chk("to_frozen", 32'h1, d < 32'h8);
		chk("to_noflag", 32'h0, irq);
		evt(1'b1);
		tick(12);
		chk("to_flag", 32'h1, irq);
		$display("test timeout done");
		// Override off: pin follows the port register
		wq(4'h0, 32'h0);
		wq(4'h1, 32'h0);
		@(posedge aclk);
		port <= 1'b1;
		tick(2);
		chk("port_hi", 32'h1, pin);
		@(posedge aclk);
		port <= 1'b0;
		tick(2);
		chk("port_lo", 32'h0, pin);
		$display("test override done");
		// Second reset in mid-run, row registers (not control A or flag) back to zero
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			rd(rows[k].idx, d, r);
			chk("reset_val", 32'h0, d);
		end
		$display("test reset done");
		summarize();
	end
endmodule // test_eight_mode_capture_timer
